// File: fxas_defines.vh
// Constants for the fixed-point add and subtract execution block.
`ifndef FXAS_DEFINES_VH
`define FXAS_DEFINES_VH

// Register byte offsets on the Wishbone bus.
`define FXAS_OFF_CTRL 8'h00
`define FXAS_OFF_STATUS 8'h04
`define FXAS_OFF_RESULT 8'h08
`define FXAS_OFF_INT_STAT 8'h0c
`define FXAS_OFF_INT_MASK 8'h10

// Control register fields.
`define FXAS_CTRL_MASK_BIT 0
`define FXAS_CTRL_ENABLE_BIT 1
`define FXAS_CTRL_RESET 2'h2

// Interrupt status and mask fields.
`define FXAS_INT_DONE_BIT 0
`define FXAS_INT_OVF_BIT 1
`define FXAS_INT_TRAP_BIT 2
`define FXAS_INT_WIDTH 3
`define FXAS_INT_RESET 3'h0

// Opcodes with the indirect bit removed.
`define FXAS_OP_ADD_IMMEDIATE 7'h20
`define FXAS_OP_ADD_HALFWORD 7'h50
`define FXAS_OP_SUB_HALFWORD 7'h58
`define FXAS_OP_ADD_WORD 7'h30
`define FXAS_OP_SUB_WORD 7'h38

// Immediate field layout and sign extension widths.
`define FXAS_IMM_SIGN_BIT 19
`define FXAS_IMM_EXT_BITS 12
`define FXAS_HALF_SIGN_BIT 15
`define FXAS_HALF_EXT_BITS 16

// Trap location for fixed-point overflow.
`define FXAS_TRAP_ADDR 32'h00000043

// Condition code low bit patterns.
`define FXAS_CC_ZERO 2'h0
`define FXAS_CC_POS 2'h2
`define FXAS_CC_NEG 2'h1

`endif

// File: fxas_adder.v
// Adder and subtractor with carry and overflow outputs.
`timescale 1ns/1ps
`default_nettype none

module fxas_adder (
  input wire [31:0] a_i,
  input wire [31:0] d_i,
  input wire sub_i,
  output wire [31:0] sum_o,
  output wire carry_o,
  output wire overflow_o
);

  wire [31:0] d_eff;
  wire [32:0] full;

  // Subtraction adds the inverted operand plus one.
  assign d_eff = sub_i ? ~d_i : d_i;
  assign full = {1'b0, a_i} + {1'b0, d_eff} + {32'h00000000, sub_i};
  assign sum_o = full[31:0];
  assign carry_o = full[32];
  assign overflow_o = (a_i[31] == d_eff[31]) && (full[31] != a_i[31]);

endmodule // fxas_adder

`default_nettype wire

// File: fxas_exec.v
// Fixed-point add and subtract execution block with Wishbone registers.
//
// Summary of operation
// - Add immediate: add extended immediate, write back.
// - Immediate sign bit 19 extended twelve positions.
// - Halfword opcodes add or subtract, write back.
// - Halfword sign extended sixteen positions to 32.
// - Word opcodes add or subtract, write back.
// - Low code bits: 00 zero, 10 positive, 01 negative.
// - Overflow flag follows fixed-point overflow.
// - Carry flag follows carry out of MSB.
// - Masked-in overflow traps to 43, register kept.
// - Masked-out overflow continues without trap.
// - Setup loads C, D, A and P.
// - Setup presets adder plus or minus select.
// - Setup raises next-instruction memory request.
// - Setup arms the register write.
// - Execution lasts one clock, writes 32 bits.
// - Subtract places A minus D on sum bus.
//
// Local design decisions: the Wishbone slave port and the register offsets.
`include "fxas_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module fxas_exec (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output wire irq_o,
  input wire start_i,
  input wire [7:0] opcode_i,
  input wire [31:0] instr_i,
  input wire [31:0] eff_op_i,
  input wire [31:0] reg_i,
  input wire [31:0] prog_addr_i,
  input wire mem_ack_i,
  output wire ready_o,
  output reg operand_setup_phase_o,
  output reg exec_phase_one_o,
  output reg adder_select_plus_o,
  output reg adder_select_minus_o,
  output reg mem_request_o,
  output reg reg_write_arm_o,
  output reg reg_wr_o,
  output reg [31:0] reg_wdata_o,
  output reg [31:0] sum_bus_o,
  output reg carry_flag_o,
  output reg overflow_flag_o,
  output reg [1:0] cc_low_o,
  output reg trap_o,
  output reg [31:0] trap_addr_o,
  output reg [31:0] next_addr_o,
  output reg illegal_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decoding.

  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_EXEC = 2'h2;

  function arith_family_decode;
    input [7:0] op;
    begin
      arith_family_decode = (op[6:0] == `FXAS_OP_ADD_IMMEDIATE) ||
                            (op[6:0] == `FXAS_OP_ADD_HALFWORD) ||
                            (op[6:0] == `FXAS_OP_SUB_HALFWORD) ||
                            (op[6:0] == `FXAS_OP_ADD_WORD) ||
                            (op[6:0] == `FXAS_OP_SUB_WORD);
    end
  endfunction

  function subtract_group_decode;
    input [7:0] op;
    begin
      subtract_group_decode = (op[6:0] == `FXAS_OP_SUB_HALFWORD) ||
                              (op[6:0] == `FXAS_OP_SUB_WORD);
    end
  endfunction

  function add_group_decode;
    input [7:0] op;
    begin
      add_group_decode = arith_family_decode(op) && !subtract_group_decode(op);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and registers.

  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] reg_c;
  reg [31:0] reg_d;
  reg [31:0] reg_a;
  reg [31:0] reg_p;
  reg [31:0] ext_op;
  reg [1:0] ctrl;
  reg [`FXAS_INT_WIDTH-1:0] int_stat;
  reg [`FXAS_INT_WIDTH-1:0] int_mask;
  reg [31:0] result;
  reg ack;
  wire [31:0] adder_sum;
  wire adder_carry;
  wire adder_ovf;
  wire take;
  wire trap_now;
  wire bus_req;
  wire bus_wr;
  wire [`FXAS_INT_WIDTH-1:0] events;
  wire [31:0] wmask;

  assign ready_o = (state == ST_IDLE) && ctrl[`FXAS_CTRL_ENABLE_BIT];
  assign take = ce_i && start_i && ready_o;

  ////////////////////////////////////////////////////////////////////////////
  // Operand sign extension.

  always @* begin
    case (opcode_i[6:0])
      `FXAS_OP_ADD_IMMEDIATE: begin
        ext_op = {{`FXAS_IMM_EXT_BITS{instr_i[`FXAS_IMM_SIGN_BIT]}},
                  instr_i[`FXAS_IMM_SIGN_BIT:0]};
      end
      `FXAS_OP_ADD_HALFWORD, `FXAS_OP_SUB_HALFWORD: begin
        ext_op = {{`FXAS_HALF_EXT_BITS{eff_op_i[`FXAS_HALF_SIGN_BIT]}},
                  eff_op_i[`FXAS_HALF_SIGN_BIT:0]};
      end
      default: begin
        ext_op = eff_op_i;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adder.

  fxas_adder u_adder (
    .a_i(reg_a),
    .d_i(reg_d),
    .sub_i(adder_select_minus_o),
    .sum_o(adder_sum),
    .carry_o(adder_carry),
    .overflow_o(adder_ovf)
  );

  assign trap_now = (state == ST_EXEC) && adder_ovf && ctrl[`FXAS_CTRL_MASK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer.

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = take && arith_family_decode(opcode_i) ? ST_SETUP : ST_IDLE;
      end
      ST_SETUP: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      operand_setup_phase_o <= 1'b0;
      exec_phase_one_o <= 1'b0;
      illegal_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      operand_setup_phase_o <= (next_state == ST_SETUP);
      exec_phase_one_o <= (next_state == ST_EXEC);
      illegal_o <= take && !arith_family_decode(opcode_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand setup.

  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_c <= 32'h00000000;
      reg_d <= 32'h00000000;
      reg_a <= 32'h00000000;
      reg_p <= 32'h00000000;
      adder_select_plus_o <= 1'b0;
      adder_select_minus_o <= 1'b0;
      reg_write_arm_o <= 1'b0;
    end else if (ce_i) begin
      if (take && arith_family_decode(opcode_i)) begin
        reg_c <= ext_op;
        reg_d <= ext_op;
        reg_a <= reg_i;
        reg_p <= prog_addr_i;
      end
      if (state == ST_SETUP) begin
        adder_select_plus_o <= add_group_decode(opcode_i);
        adder_select_minus_o <= subtract_group_decode(opcode_i);
        reg_write_arm_o <= 1'b1;
      end else if (state == ST_EXEC) begin
        adder_select_plus_o <= 1'b0;
        adder_select_minus_o <= 1'b0;
        reg_write_arm_o <= 1'b0;
      end
    end
  end

  // The opcode must stay stable from the start request until execution ends.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_request_o <= 1'b0;
    end else if (ce_i) begin
      if (state == ST_SETUP) begin
        mem_request_o <= 1'b1;
      end else if (mem_ack_i) begin
        mem_request_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution phase and condition codes.

  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_wr_o <= 1'b0;
      reg_wdata_o <= 32'h00000000;
      sum_bus_o <= 32'h00000000;
      carry_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      cc_low_o <= `FXAS_CC_ZERO;
      trap_o <= 1'b0;
      trap_addr_o <= 32'h00000000;
      next_addr_o <= 32'h00000000;
      result <= 32'h00000000;
    end else if (ce_i) begin
      reg_wr_o <= 1'b0;
      trap_o <= 1'b0;
      if (state == ST_EXEC) begin
        sum_bus_o <= adder_sum;
        result <= adder_sum;
        reg_wdata_o <= adder_sum;
        reg_wr_o <= reg_write_arm_o && !trap_now;
        carry_flag_o <= adder_carry;
        overflow_flag_o <= adder_ovf;
        if (adder_sum == 32'h00000000) begin
          cc_low_o <= `FXAS_CC_ZERO;
        end else if (adder_sum[31]) begin
          cc_low_o <= `FXAS_CC_NEG;
        end else begin
          cc_low_o <= `FXAS_CC_POS;
        end
        trap_o <= trap_now;
        trap_addr_o <= `FXAS_TRAP_ADDR;
        next_addr_o <= reg_p;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear.

  assign bus_req = cyc_i && stb_i;
  assign bus_wr = bus_req && we_i && !ack;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign events = {trap_now, (state == ST_EXEC) && adder_ovf, state == ST_EXEC};

  genvar gi;
  generate
    for (gi = 0; gi < `FXAS_INT_WIDTH; gi = gi + 1) begin : g_int
      always @(posedge clk_i) begin
        if (rst_i) begin
          int_stat[gi] <= 1'b0;
        end else if (ce_i) begin
          if (events[gi]) begin
            int_stat[gi] <= 1'b1;
          end else if (bus_wr && adr_i == `FXAS_OFF_INT_STAT && dat_i[gi] && wmask[gi]) begin
            int_stat[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign irq_o = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register access.

  assign ack_o = ack;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      ctrl <= `FXAS_CTRL_RESET;
      int_mask <= `FXAS_INT_RESET;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack <= bus_req && !ack;
      if (bus_wr && adr_i == `FXAS_OFF_CTRL && sel_i[0]) begin
        ctrl <= dat_i[1:0];
      end
      if (bus_wr && adr_i == `FXAS_OFF_INT_MASK && sel_i[0]) begin
        int_mask <= dat_i[`FXAS_INT_WIDTH-1:0];
      end
      if (bus_req && !ack) begin
        case (adr_i)
          `FXAS_OFF_CTRL: begin
            dat_o <= {30'h0, ctrl};
          end
          `FXAS_OFF_STATUS: begin
            dat_o <= {24'h000000, mem_request_o, trap_o, state, carry_flag_o,
                      overflow_flag_o, cc_low_o};
          end
          `FXAS_OFF_RESULT: begin
            dat_o <= result;
          end
          `FXAS_OFF_INT_STAT: begin
            dat_o <= {29'h0, int_stat};
          end
          `FXAS_OFF_INT_MASK: begin
            dat_o <= {29'h0, int_mask};
          end
          default: begin
            dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // fxas_exec

`default_nettype wire

// File: fxas_exec_monitor.sv
// Assertion checker for the add and subtract execution block.
`timescale 1ns/1ps
`default_nettype none
`include "fxas_defines.vh"
module fxas_exec_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] opcode_i,
  input wire logic ack_o,
  input wire logic operand_setup_phase_o,
  input wire logic exec_phase_one_o,
  input wire logic adder_select_plus_o,
  input wire logic adder_select_minus_o,
  input wire logic mem_request_o,
  input wire logic reg_write_arm_o,
  input wire logic reg_wr_o,
  input wire logic [31:0] reg_wdata_o,
  input wire logic [31:0] sum_bus_o,
  input wire logic [1:0] cc_low_o,
  input wire logic overflow_flag_o,
  input wire logic trap_o,
  input wire logic [31:0] trap_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_walk;
    operand_setup_phase_o ##1 exec_phase_one_o ##1 (reg_wr_o ^ trap_o);
  endsequence
  a_phase_walk: assert property (operand_setup_phase_o |-> s_walk)
    else $error("phase walk broken");
  a_exec_single: assert property (exec_phase_one_o |=> !exec_phase_one_o)
    else $error("exec phase too long");
  a_select_dir: assert property (exec_phase_one_o |-> adder_select_minus_o == opcode_i[3])
    else $error("adder select wrong");
  a_select_one: assert property (exec_phase_one_o |-> adder_select_plus_o != adder_select_minus_o)
    else $error("adder select not single");
  a_fetch_arm: assert property (exec_phase_one_o |-> mem_request_o && reg_write_arm_o)
    else $error("fetch or arm missing");
  a_trap_target: assert property (trap_o |-> trap_addr_o == `FXAS_TRAP_ADDR && overflow_flag_o && !reg_wr_o)
    else $error("trap wrong");
  a_write_sum: assert property (reg_wr_o |-> reg_wdata_o == sum_bus_o && $past(reg_write_arm_o))
    else $error("write not armed sum");
  a_code_bits: assert property (reg_wr_o |-> cc_low_o == ((reg_wdata_o == 32'h0) ? `FXAS_CC_ZERO :
    (reg_wdata_o[31] ? `FXAS_CC_NEG : `FXAS_CC_POS))) else $error("code bits wrong");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
endmodule // fxas_exec_monitor
bind fxas_exec fxas_exec_monitor i_fxas_exec_monitor (.clk_i(clk_i), .rst_i(rst_i), .opcode_i(opcode_i),
  .ack_o(ack_o), .operand_setup_phase_o(operand_setup_phase_o), .exec_phase_one_o(exec_phase_one_o),
  .adder_select_plus_o(adder_select_plus_o), .adder_select_minus_o(adder_select_minus_o),
  .mem_request_o(mem_request_o), .reg_write_arm_o(reg_write_arm_o), .reg_wr_o(reg_wr_o),
  .reg_wdata_o(reg_wdata_o), .sum_bus_o(sum_bus_o), .cc_low_o(cc_low_o), .overflow_flag_o(overflow_flag_o),
  .trap_o(trap_o), .trap_addr_o(trap_addr_o));
`default_nettype wire

// File: fxas_regfile_model.sv
// General register and next-fetch memory model.
`timescale 1ns/1ps
`default_nettype none
module fxas_regfile_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic [1:0] dly_i,
  input wire logic mem_request_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_o,
  output logic mem_ack_o
);
  logic [1:0] wait_cnt;
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    if (rst_i) begin
      reg_o <= 32'h0;
      wait_cnt <= 2'h0;
    end else begin
      if (load_i) begin
        reg_o <= load_val_i;
      end else if (reg_wr_i) begin
        reg_o <= reg_wdata_i;
      end
      if (mem_request_i && !mem_ack_o) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == dly_i) begin
          mem_ack_o <= 1'b1;
          wait_cnt <= 2'h0;
        end
      end
    end
  end
endmodule // fxas_regfile_model
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the add and subtract execution block.
`timescale 1ns/1ps
`default_nettype none
`include "fxas_defines.vh"
module testbench;
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] opnd;
    logic [31:0] rg;
    logic msk;
    logic [31:0] sum;
    logic [3:0] fl;
  } fxas_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0, load = 1'b0, ce = 1'b1;
  logic [7:0] adr = 8'h0, opc = 8'h0;
  logic [31:0] dat_w = 32'h0, instr = 32'h0, prog = 32'h0, load_val = 32'h0, q;
  logic [1:0] dly = 2'h0;
  wire logic ack_o, irq_o, ready_o, mreq, mack, reg_wr, trap, ovf, carry, illeg;
  wire logic [31:0] dat_o, rg_q, wdata, nxt;
  wire logic [1:0] cc;
  int n_fail = 0, n_checks = 0;
  fxas_row_t rows[9] = '{'{8'h20, 32'h80000, 32'h80000, 1'b0, 32'h0, 4'h8},
    '{8'h20, 32'h5, 32'h1, 1'b0, 32'h6, 4'h2}, '{8'h20, 32'h7ffff, 32'h7fffffff, 1'b1, 32'h0, 4'h5},
    '{8'h50, 32'h1234ffff, 32'h0, 1'b0, 32'hffffffff, 4'h1}, '{8'h58, 32'h1, 32'h80000000, 1'b0, 32'h7fffffff, 4'he},
    '{8'h58, 32'h1, 32'h80000000, 1'b1, 32'h0, 4'he}, '{8'hb0, 32'h7fffffff, 32'h1, 1'b0, 32'h80000000, 4'h5},
    '{8'h38, 32'h5, 32'h5, 1'b0, 32'h0, 4'h8}, '{8'h38, 32'h1, 32'h0, 1'b0, 32'hffffffff, 4'h1}};

  fxas_exec i_fxas_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .start_i(start),
    .opcode_i(opc), .instr_i(instr), .eff_op_i(instr), .reg_i(rg_q), .prog_addr_i(prog), .mem_ack_i(mack),
    .ready_o(ready_o), .operand_setup_phase_o(), .exec_phase_one_o(), .adder_select_plus_o(),
    .adder_select_minus_o(), .mem_request_o(mreq), .reg_write_arm_o(), .reg_wr_o(reg_wr), .reg_wdata_o(wdata),
    .sum_bus_o(), .carry_flag_o(carry), .overflow_flag_o(ovf), .cc_low_o(cc), .trap_o(trap), .trap_addr_o(),
    .next_addr_o(nxt), .illegal_o(illeg));
  fxas_regfile_model i_fxas_regfile_model (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .load_val_i(load_val),
    .dly_i(dly), .mem_request_i(mreq), .reg_wr_i(reg_wr), .reg_wdata_i(wdata), .reg_o(rg_q), .mem_ack_o(mack));

  always #20 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Called right after a rising edge; ack and read data are taken at the rising edge that samples ack high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run(input fxas_row_t r);
    logic tx;
    tx = r.msk & r.fl[2];
    wb(1'b1, `FXAS_OFF_CTRL, {30'h0, 1'b1, r.msk}, q);
    load <= 1'b1;
    load_val <= r.rg;
    dly <= r.opnd[1:0];
    @(posedge clk_i);
    load <= 1'b0;
    start <= 1'b1;
    opc <= r.op;
    instr <= r.opnd;
    prog <= ~r.opnd;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("flags", {28'h0, r.fl}, {28'h0, carry, ovf, cc});
    chk("trap", {31'h0, tx}, {31'h0, trap});
    chk("write", {31'h0, !tx}, {31'h0, reg_wr});
    if (!tx) begin
      chk("result", r.sum, wdata);
      chk("next", ~r.opnd, nxt);
    end
    @(posedge clk_i);
    @(negedge clk_i);
    chk("register", tx ? r.rg : r.sum, rg_q);
    @(posedge clk_i);
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("ready", 32'h1, {31'h0, ready_o});
    chk("reset outputs", 32'h0, {26'h0, carry, ovf, cc, reg_wr, trap});
    @(posedge clk_i);
    wb(1'b0, `FXAS_OFF_CTRL, 32'h0, q);
    chk("ctrl", {30'h0, `FXAS_CTRL_RESET}, q);
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i]);
    end
    $display("row tests done");
    wb(1'b0, `FXAS_OFF_RESULT, 32'h0, q);
    chk("result register", 32'hffffffff, q);
    wb(1'b0, `FXAS_OFF_STATUS, 32'h0, q);
    chk("status register", 32'h1, q);
    wb(1'b0, `FXAS_OFF_INT_STAT, 32'h0, q);
    chk("status", 32'h7, q);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, `FXAS_OFF_INT_MASK, 32'h7, q);
    chk("irq set", 32'h1, {31'h0, irq_o});
    wb(1'b1, `FXAS_OFF_INT_STAT, 32'h7, q);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b1, `FXAS_OFF_CTRL, 32'h0, q);
    chk("disabled", 32'h0, {31'h0, ready_o});
    $display("register tests done");
    // A start held while the clock enable is low must not be taken.
    wb(1'b1, `FXAS_OFF_CTRL, 32'h3, q);
    ce <= 1'b0;
    start <= 1'b1;
    opc <= 8'h30;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("frozen ready", 32'h1, {31'h0, ready_o});
    @(posedge clk_i);
    ce <= 1'b1;
    opc <= 8'h10;
    @(posedge clk_i);
    start <= 1'b0;
    @(negedge clk_i);
    chk("illegal", 32'h3, {30'h0, illeg, ready_o});
    // A reset in the middle of operand setup abandons the instruction.
    @(posedge clk_i);
    start <= 1'b1;
    opc <= 8'h30;
    @(posedge clk_i);
    start <= 1'b0;
    rst_i <= 1'b1;
    @(negedge clk_i);
    chk("busy", 32'h0, {31'h0, ready_o});
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("mid reset outputs", 32'h0, {26'h0, carry, ovf, cc, reg_wr, trap});
    chk("mid reset ready", 32'h1, {31'h0, ready_o});
    @(posedge clk_i);
    wb(1'b0, `FXAS_OFF_CTRL, 32'h0, q);
    chk("ctrl after reset", {30'h0, `FXAS_CTRL_RESET}, q);
    $display("awkward tests done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
